// File: rtl/dbd_pkg.sv
// constants, types and state codes shared by the dual byte driver with boundary scan
//
// Function
// - two 9-bit channels, outputs follow inputs uninverted
// - byte drives only when both enables low
// - input pins get observe-only cells, path untouched
// - output pins get observe-and-control cells
// - active-high internal enable per byte, controllable cell
// - each internal enable governs only its byte
// - bypass is one stage capturing zero
// - 8-bit instruction register captures fixed 01-ending value
// - no identification register; captured value identifies
// - decode extest, clamp, highz, sample; others bypass
// - boundary register is one 42-cell chain
// - boundary order: enables, inputs, outputs descending
// - four-wire test port sequenced by external controller
package dbd_pkg;

  // ****************************************************************
  // widths and lengths
  // ****************************************************************
  localparam int DATA_W = 9;     // bits per byte lane
  localparam int IR_LEN = 8;     // instruction register length
  localparam int BSR_LEN = 42;   // boundary register length
  localparam int SYNC_STAGES = 2; // flip-flops on every input pin

  // ****************************************************************
  // boundary register positions
  // ****************************************************************
  localparam int BSR_ONE_EN_FIRST = 41;
  localparam int BSR_ONE_EN_SECOND = 40;
  localparam int BSR_ONE_INTERNAL = 39;
  localparam int BSR_TWO_EN_FIRST = 38;
  localparam int BSR_TWO_EN_SECOND = 37;
  localparam int BSR_TWO_INTERNAL = 36;
  localparam int BSR_ONE_IN_TOP = 35;  // input 0 here, input 8 at 27
  localparam int BSR_TWO_IN_TOP = 26;  // input 0 here, input 8 at 18
  localparam int BSR_ONE_OUT_TOP = 17; // output 0 here, output 8 at 9
  localparam int BSR_TWO_OUT_TOP = 8;  // output 0 here, output 8 at 0

  // ****************************************************************
  // instruction codes and reset values
  // ****************************************************************
  localparam logic [7:0] INS_EXTEST = 8'h00;
  localparam logic [7:0] INS_CLAMP = 8'h82;
  localparam logic [7:0] INS_HIGHZ = 8'h03;
  // captured pattern doubles as sample/preload code; value is arbitrary
  localparam logic [7:0] IR_CAPTURE_DEFAULT = 8'h45;
  localparam logic [7:0] IR_RESET = 8'hFF;     // bypass after test reset
  localparam logic [41:0] BSR_RESET = 42'h000_0000_0000;

  // ****************************************************************
  // test access port states, one-hot
  // ****************************************************************
  typedef enum logic [15:0] {
    ST_RESET    = 16'h0001,
    ST_IDLE     = 16'h0002,
    ST_SEL_DR   = 16'h0004,
    ST_CAP_DR   = 16'h0008,
    ST_SH_DR    = 16'h0010,
    ST_EX1_DR   = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EX2_DR   = 16'h0080,
    ST_UPD_DR   = 16'h0100,
    ST_SEL_IR   = 16'h0200,
    ST_CAP_IR   = 16'h0400,
    ST_SH_IR    = 16'h0800,
    ST_EX1_IR   = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EX2_IR   = 16'h4000,
    ST_UPD_IR   = 16'h8000
  } dbd_tap_state_t;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic one_en_first_n;
    logic one_en_second_n;
    logic two_en_first_n;
    logic two_en_second_n;
    logic [8:0] one_data;
    logic [8:0] two_data;
  } dbd_sys_in_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } dbd_tap_in_t;

endpackage

// File: rtl/dbd_sync.sv
// two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module dbd_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta; // first stage, read only by the second
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // next values: plain shift
  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  // registers, frozen while ce is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= next_meta;
      q <= next_q;
    end
  end

endmodule
`default_nettype wire

// File: rtl/dbd_tap_fsm.sv
// test access port state machine, advanced on each detected test clock rise
`timescale 1ns/100ps
`default_nettype none
module dbd_tap_fsm (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // sampled test port
  input wire logic tck_rise,
  input wire logic tms,
  // state
  output dbd_pkg::dbd_tap_state_t state
);

  dbd_pkg::dbd_tap_state_t next_state;

  // standard sixteen-state walk, one step per test clock rise
  always_comb begin
    next_state = state;
    if (tck_rise) begin
      unique case (state)
        dbd_pkg::ST_RESET:    next_state = tms ? dbd_pkg::ST_RESET : dbd_pkg::ST_IDLE;
        dbd_pkg::ST_IDLE:     next_state = tms ? dbd_pkg::ST_SEL_DR : dbd_pkg::ST_IDLE;
        dbd_pkg::ST_SEL_DR:   next_state = tms ? dbd_pkg::ST_SEL_IR : dbd_pkg::ST_CAP_DR;
        dbd_pkg::ST_CAP_DR:   next_state = tms ? dbd_pkg::ST_EX1_DR : dbd_pkg::ST_SH_DR;
        dbd_pkg::ST_SH_DR:    next_state = tms ? dbd_pkg::ST_EX1_DR : dbd_pkg::ST_SH_DR;
        dbd_pkg::ST_EX1_DR:   next_state = tms ? dbd_pkg::ST_UPD_DR : dbd_pkg::ST_PAUSE_DR;
        dbd_pkg::ST_PAUSE_DR: next_state = tms ? dbd_pkg::ST_EX2_DR : dbd_pkg::ST_PAUSE_DR;
        dbd_pkg::ST_EX2_DR:   next_state = tms ? dbd_pkg::ST_UPD_DR : dbd_pkg::ST_SH_DR;
        dbd_pkg::ST_UPD_DR:   next_state = tms ? dbd_pkg::ST_SEL_DR : dbd_pkg::ST_IDLE;
        dbd_pkg::ST_SEL_IR:   next_state = tms ? dbd_pkg::ST_RESET : dbd_pkg::ST_CAP_IR;
        dbd_pkg::ST_CAP_IR:   next_state = tms ? dbd_pkg::ST_EX1_IR : dbd_pkg::ST_SH_IR;
        dbd_pkg::ST_SH_IR:    next_state = tms ? dbd_pkg::ST_EX1_IR : dbd_pkg::ST_SH_IR;
        dbd_pkg::ST_EX1_IR:   next_state = tms ? dbd_pkg::ST_UPD_IR : dbd_pkg::ST_PAUSE_IR;
        dbd_pkg::ST_PAUSE_IR: next_state = tms ? dbd_pkg::ST_EX2_IR : dbd_pkg::ST_PAUSE_IR;
        dbd_pkg::ST_EX2_IR:   next_state = tms ? dbd_pkg::ST_UPD_IR : dbd_pkg::ST_SH_IR;
        dbd_pkg::ST_UPD_IR:   next_state = tms ? dbd_pkg::ST_SEL_DR : dbd_pkg::ST_IDLE;
        // a corrupted one-hot code falls back to test reset
        default:              next_state = dbd_pkg::ST_RESET;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= dbd_pkg::ST_RESET;
    end else if (ce) begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

// File: rtl/dbd_top.sv
// dual 9-bit non-inverting driver with boundary-scan test logic, sampled test port
`timescale 1ns/100ps
`default_nettype none
module dbd_top #(
  // captured instruction value, also the sample/preload code
  parameter logic [7:0] IR_CAPTURE = dbd_pkg::IR_CAPTURE_DEFAULT
) (
  // clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CE,
  // test access port
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE_N,
  // side one system pins
  input wire logic [8:0] SIDE_ONE_DATA_IN,
  input wire logic SIDE_ONE_ENABLE_FIRST_N,
  input wire logic SIDE_ONE_ENABLE_SECOND_N,
  output logic [8:0] SIDE_ONE_DATA_OUT,
  output logic [8:0] SIDE_ONE_DATA_OE_N,
  // side two system pins
  input wire logic [8:0] SIDE_TWO_DATA_IN,
  input wire logic SIDE_TWO_ENABLE_FIRST_N,
  input wire logic SIDE_TWO_ENABLE_SECOND_N,
  output logic [8:0] SIDE_TWO_DATA_OUT,
  output logic [8:0] SIDE_TWO_DATA_OE_N
);

  // ****************************************************************
  // functions
  // ****************************************************************

  // snapshot of every cell's observed value for capture-dr
  function automatic logic [41:0] capture_bsr(input dbd_pkg::dbd_sys_in_t p);
    logic [41:0] v;
    v = dbd_pkg::BSR_RESET;
    // input pins are only observed, never steered
    v[dbd_pkg::BSR_ONE_EN_FIRST] = p.one_en_first_n;
    v[dbd_pkg::BSR_ONE_EN_SECOND] = p.one_en_second_n;
    v[dbd_pkg::BSR_TWO_EN_FIRST] = p.two_en_first_n;
    v[dbd_pkg::BSR_TWO_EN_SECOND] = p.two_en_second_n;
    // control cells see the functional active-high enables
    v[dbd_pkg::BSR_ONE_INTERNAL] = func_enable(p.one_en_first_n, p.one_en_second_n);
    v[dbd_pkg::BSR_TWO_INTERNAL] = func_enable(p.two_en_first_n, p.two_en_second_n);
    for (int i = 0; i < dbd_pkg::DATA_W; i++) begin
      v[dbd_pkg::BSR_ONE_IN_TOP - i] = p.one_data[i];
      v[dbd_pkg::BSR_TWO_IN_TOP - i] = p.two_data[i];
      v[dbd_pkg::BSR_ONE_OUT_TOP - i] = p.one_data[i];
      v[dbd_pkg::BSR_TWO_OUT_TOP - i] = p.two_data[i]; // output 8 lands on bit 0
    end
    return v;
  endfunction

  // byte enable: both pins low
  function automatic logic func_enable(input logic first_n, input logic second_n);
    return ~(first_n | second_n);
  endfunction

  // pick a byte's output cells from the update stage, output 0 highest
  function automatic logic [8:0] out_cells(input logic [41:0] v, input int top);
    logic [8:0] r;
    r = '0;
    for (int i = 0; i < dbd_pkg::DATA_W; i++) begin
      r[i] = v[top - i];
    end
    return r;
  endfunction

  // ****************************************************************
  // pin synchronisers and test clock edges
  // ****************************************************************
  dbd_pkg::dbd_sys_in_t sys_raw; // system pins as arrived
  dbd_pkg::dbd_sys_in_t sys;     // system pins after two flops
  dbd_pkg::dbd_tap_in_t tap_raw; // test pins as arrived
  dbd_pkg::dbd_tap_in_t tap;     // test pins after two flops
  logic tck_prev;                // synced test clock, one cycle older
  logic tck_rise;                // rising test clock edge seen this cycle
  logic tck_fall;                // falling test clock edge seen this cycle

  assign sys_raw = '{one_en_first_n: SIDE_ONE_ENABLE_FIRST_N, one_en_second_n: SIDE_ONE_ENABLE_SECOND_N,
                     two_en_first_n: SIDE_TWO_ENABLE_FIRST_N, two_en_second_n: SIDE_TWO_ENABLE_SECOND_N,
                     one_data: SIDE_ONE_DATA_IN, two_data: SIDE_TWO_DATA_IN};
  assign tap_raw = '{tck: TCK, tms: TMS, tdi: TDI};

  // system pins; they add two cycles of latency to the data path
  dbd_sync #(.W($bits(dbd_pkg::dbd_sys_in_t))) u_sys_sync (
    .clk(REF_CLK),
    .rst(RESET),
    .ce(CE),
    .d(sys_raw),
    .q(sys)
  );

  // test port pins; tms and tdi stay aligned with tck through equal stages
  dbd_sync #(.W($bits(dbd_pkg::dbd_tap_in_t))) u_tap_sync (
    .clk(REF_CLK),
    .rst(RESET),
    .ce(CE),
    .d(tap_raw),
    .q(tap)
  );

  assign tck_rise = tap.tck & ~tck_prev;
  assign tck_fall = ~tap.tck & tck_prev;

  // ****************************************************************
  // test access port controller
  // ****************************************************************
  dbd_pkg::dbd_tap_state_t state;

  dbd_tap_fsm u_fsm (
    .clk(REF_CLK),
    .rst(RESET),
    .ce(CE),
    .tck_rise(tck_rise),
    .tms(tap.tms),
    .state(state)
  );

  // ****************************************************************
  // instruction decode
  // ****************************************************************
  logic [7:0] ir;       // current instruction
  logic sel_bsr;        // boundary register between tdi and tdo
  logic test_ctrl;      // update stages own the system outputs
  logic highz;          // every system output floats

  // codes outside the table select bypass
  always_comb begin
    sel_bsr = (ir == dbd_pkg::INS_EXTEST) || (ir == IR_CAPTURE);
    test_ctrl = (ir == dbd_pkg::INS_EXTEST) || (ir == dbd_pkg::INS_CLAMP);
    highz = (ir == dbd_pkg::INS_HIGHZ);
  end

  // ****************************************************************
  // scan registers
  // ****************************************************************
  logic [7:0] ir_shift;        // instruction shift stage
  logic [41:0] boundary_register;            // boundary register shift/capture stage
  logic [41:0] upd;            // boundary update stage
  logic byp;                   // bypass stage
  logic tdo_q;                 // serial output flop
  logic tdo_oe_n_q;            // serial output enable flop, low drives
  logic [7:0] next_ir;
  logic [7:0] next_ir_shift;
  logic [41:0] next_bsr;
  logic [41:0] next_upd;
  logic next_byp;
  logic next_tdo;
  logic next_tdo_oe_n;
  logic next_tck_prev;
  logic in_shift;              // in shift-ir or shift-dr

  // capture and shift on rising test clock, update and output on falling
  always_comb begin
    next_ir = ir;
    next_ir_shift = ir_shift;
    next_bsr = boundary_register;
    next_upd = upd;
    next_byp = byp;
    next_tdo = tdo_q;
    next_tdo_oe_n = tdo_oe_n_q;
    next_tck_prev = tap.tck;
    in_shift = (state == dbd_pkg::ST_SH_IR) || (state == dbd_pkg::ST_SH_DR);
    if (tck_rise) begin
      unique case (state)
        dbd_pkg::ST_CAP_IR: next_ir_shift = IR_CAPTURE; // pseudo identity
        dbd_pkg::ST_SH_IR: next_ir_shift = {tap.tdi, ir_shift[7:1]};
        dbd_pkg::ST_CAP_DR: begin
          if (sel_bsr) begin
            next_bsr = capture_bsr(sys);
          end else begin
            next_byp = 1'b0; // bypass captures zero
          end
        end
        dbd_pkg::ST_SH_DR: begin
          if (sel_bsr) begin
            next_bsr = {tap.tdi, boundary_register[41:1]}; // one 42-cell chain
          end else begin
            next_byp = tap.tdi;
          end
        end
        default: begin
          // other states hold the shift stages
        end
      endcase
    end
    if (tck_fall) begin
      // update-ir loads the instruction; test reset forces bypass
      if (state == dbd_pkg::ST_UPD_IR) begin
        next_ir = ir_shift;
      end else if (state == dbd_pkg::ST_RESET) begin
        next_ir = dbd_pkg::IR_RESET;
      end
      // only boundary instructions may preload the update stage
      if ((state == dbd_pkg::ST_UPD_DR) && sel_bsr) begin
        next_upd = boundary_register;
      end
      // serial output moves on the falling edge, floats outside shift
      next_tdo_oe_n = ~in_shift;
      if (state == dbd_pkg::ST_SH_IR) begin
        next_tdo = ir_shift[0];
      end else if (state == dbd_pkg::ST_SH_DR) begin
        next_tdo = sel_bsr ? boundary_register[0] : byp;
      end
    end
  end

  // scan registers; update stage holds across test reset so preloads survive
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ir <= dbd_pkg::IR_RESET;
      ir_shift <= dbd_pkg::IR_RESET;
      boundary_register <= dbd_pkg::BSR_RESET;
      upd <= dbd_pkg::BSR_RESET;
      byp <= 1'b0;
      tdo_q <= 1'b0;
      tdo_oe_n_q <= 1'b1;
      tck_prev <= 1'b0;
    end else if (CE) begin
      ir <= next_ir;
      ir_shift <= next_ir_shift;
      boundary_register <= next_bsr;
      upd <= next_upd;
      byp <= next_byp;
      tdo_q <= next_tdo;
      tdo_oe_n_q <= next_tdo_oe_n;
      tck_prev <= next_tck_prev;
    end
  end

  assign TDO = tdo_q;
  assign TDO_OE_N = tdo_oe_n_q;

  // ****************************************************************
  // system output path
  // ****************************************************************
  logic [8:0] next_one_out;
  logic [8:0] next_two_out;
  logic [8:0] next_one_oe_n;
  logic [8:0] next_two_oe_n;
  logic one_en;   // side one internal enable, active high
  logic two_en;   // side two internal enable, active high

  // functional path or update stages; each enable reaches its own byte only
  always_comb begin
    if (test_ctrl) begin
      one_en = upd[dbd_pkg::BSR_ONE_INTERNAL];
      two_en = upd[dbd_pkg::BSR_TWO_INTERNAL];
      next_one_out = out_cells(upd, dbd_pkg::BSR_ONE_OUT_TOP);
      next_two_out = out_cells(upd, dbd_pkg::BSR_TWO_OUT_TOP);
    end else begin
      one_en = func_enable(sys.one_en_first_n, sys.one_en_second_n);
      two_en = func_enable(sys.two_en_first_n, sys.two_en_second_n);
      next_one_out = sys.one_data; // no inversion
      next_two_out = sys.two_data;
    end
    // highz floats everything whatever the cells hold
    next_one_oe_n = {dbd_pkg::DATA_W{~one_en | highz}};
    next_two_oe_n = {dbd_pkg::DATA_W{~two_en | highz}};
  end

  // output flops; outputs float during reset, then drive zeros since the synchronisers reset the enables low
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      SIDE_ONE_DATA_OUT <= '0;
      SIDE_TWO_DATA_OUT <= '0;
      SIDE_ONE_DATA_OE_N <= '1;
      SIDE_TWO_DATA_OE_N <= '1;
    end else if (CE) begin
      SIDE_ONE_DATA_OUT <= next_one_out;
      SIDE_TWO_DATA_OUT <= next_two_out;
      SIDE_ONE_DATA_OE_N <= next_one_oe_n;
      SIDE_TWO_DATA_OE_N <= next_two_oe_n;
    end
  end

endmodule
`default_nettype wire

// File: verification/dbd_checker.sv
// pin-level assertions for the dual byte driver with boundary scan
`timescale 1ns/100ps
`default_nettype none
module dbd_checker (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // test access port
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDO,
  input wire logic TDO_OE_N,
  // side one
  input wire logic [8:0] SIDE_ONE_DATA_IN,
  input wire logic SIDE_ONE_ENABLE_FIRST_N,
  input wire logic SIDE_ONE_ENABLE_SECOND_N,
  input wire logic [8:0] SIDE_ONE_DATA_OUT,
  input wire logic [8:0] SIDE_ONE_DATA_OE_N,
  // side two
  input wire logic [8:0] SIDE_TWO_DATA_IN,
  input wire logic SIDE_TWO_ENABLE_FIRST_N,
  input wire logic SIDE_TWO_ENABLE_SECOND_N,
  input wire logic [8:0] SIDE_TWO_DATA_OUT,
  input wire logic [8:0] SIDE_TWO_DATA_OE_N
);
  // ****************************************************************
  // helper: test clock rises seen with mode select high
  // ****************************************************************
  logic tck_q; // test clock one cycle ago
  logic [2:0] ones; // saturating count of mode-high rises
  logic tlr; // port parked in test-logic-reset
  // six rises, not five: the count ignores the pin delay, so it waits one more
  assign tlr = ones >= 3'h6;
  // count on raw pins, one flop behind the test clock
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      tck_q <= 1'b0;
      ones <= 3'h0;
    end else begin
      tck_q <= TCK;
      if (TCK && !tck_q) begin
        ones <= !TMS ? 3'h0 : (ones == 3'h7) ? ones : ones + 3'h1;
      end
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // parked long enough for the pin flops to flush
  sequence s_parked;
    tlr [*4];
  endsequence
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_one_data_follows: assert property (s_parked ##0 !SIDE_ONE_DATA_OE_N[0] |->
    SIDE_ONE_DATA_OUT == $past(SIDE_ONE_DATA_IN, 3)) else $error("side one data does not follow its inputs");
  a_two_data_follows: assert property (s_parked ##0 !SIDE_TWO_DATA_OE_N[0] |->
    SIDE_TWO_DATA_OUT == $past(SIDE_TWO_DATA_IN, 3)) else $error("side two data does not follow its inputs");
  a_one_enable_pair: assert property (s_parked |-> SIDE_ONE_DATA_OE_N[0] ==
    ($past(SIDE_ONE_ENABLE_FIRST_N, 3) | $past(SIDE_ONE_ENABLE_SECOND_N, 3))) else $error("side one enable wrong");
  a_two_enable_pair: assert property (s_parked |-> SIDE_TWO_DATA_OE_N[0] ==
    ($past(SIDE_TWO_ENABLE_FIRST_N, 3) | $past(SIDE_TWO_ENABLE_SECOND_N, 3))) else $error("side two enable wrong");
  a_byte_oe_equal: assert property (SIDE_ONE_DATA_OE_N == {9{SIDE_ONE_DATA_OE_N[0]}} &&
    SIDE_TWO_DATA_OE_N == {9{SIDE_TWO_DATA_OE_N[0]}}) else $error("byte enables differ within a byte");
  a_tdo_on_fall: assert property ($changed(TDO) |-> !$past(TCK))
    else $error("test data out moved while test clock high");
  a_tdo_oe_fall: assert property ($changed(TDO_OE_N) |-> !$past(TCK))
    else $error("test data out enable moved while test clock high");
  a_tdo_parked_float: assert property (tlr |-> TDO_OE_N)
    else $error("test data out driven outside a shift");
endmodule
bind dbd_top dbd_checker chk_u (
  .REF_CLK(REF_CLK), .RESET(RESET), .TCK(TCK), .TMS(TMS), .TDO(TDO), .TDO_OE_N(TDO_OE_N),
  .SIDE_ONE_DATA_IN(SIDE_ONE_DATA_IN), .SIDE_ONE_ENABLE_FIRST_N(SIDE_ONE_ENABLE_FIRST_N),
  .SIDE_ONE_ENABLE_SECOND_N(SIDE_ONE_ENABLE_SECOND_N), .SIDE_ONE_DATA_OUT(SIDE_ONE_DATA_OUT),
  .SIDE_ONE_DATA_OE_N(SIDE_ONE_DATA_OE_N), .SIDE_TWO_DATA_IN(SIDE_TWO_DATA_IN),
  .SIDE_TWO_ENABLE_FIRST_N(SIDE_TWO_ENABLE_FIRST_N), .SIDE_TWO_ENABLE_SECOND_N(SIDE_TWO_ENABLE_SECOND_N),
  .SIDE_TWO_DATA_OUT(SIDE_TWO_DATA_OUT), .SIDE_TWO_DATA_OE_N(SIDE_TWO_DATA_OE_N)
);
`default_nettype wire

// File: verification/dbd_ctl_model.sv
// controller model that walks the test port of the driver
`timescale 1ns/100ps
`default_nettype none
module dbd_ctl_model (
  // fast clock, used only to pace the test clock
  input wire logic clk,
  // test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  // ****************************************************************
  // pacing and idle levels
  // ****************************************************************
  int half = 4; // fast cycles per test clock phase; below 3 tdo is sampled before the pin flops let it move
  // test clock stands still between frames; data in rests at its pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one test clock period: fall and change lines, hold, sample, rise
  task automatic step(input logic m, input logic d, output logic q, output logic qz);
    @(negedge clk);
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (half) @(negedge clk);
    q = tdo;
    qz = tdo_oe_n;
    tck = 1'b1;
    repeat (half - 1) @(negedge clk);
  endtask
  // six rises with mode high park the port in test-logic-reset
  task automatic park;
    logic q, qz;
    repeat (6) step(1'b1, 1'b1, q, qz);
  endtask
  // idle, walk to a shift state, move n bits first bit first, update, idle
  task automatic scan(input logic ir, input int n, input logic [41:0] din,
                      output logic [41:0] dout, output logic oe_bad);
    logic q, qz;
    dout = '0;
    oe_bad = 1'b0;
    step(1'b0, 1'b1, q, qz);
    step(1'b1, 1'b1, q, qz);
    if (ir) step(1'b1, 1'b1, q, qz);
    step(1'b0, 1'b1, q, qz);
    step(1'b0, 1'b1, q, qz);
    oe_bad = !qz; // still floated after capture
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q, qz);
      dout[i] = q;
      oe_bad = oe_bad | qz;
    end
    step(1'b1, 1'b1, q, qz);
    oe_bad = oe_bad | !qz; // floated again after exit
    step(1'b0, 1'b1, q, qz);
  endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the dual byte driver with boundary scan
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ****************************************************************
  // pins and counters
  // ****************************************************************
  localparam logic [7:0] CAP = 8'h6D; // captured code, value arbitrary, ends in 01
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe_n;
  logic [3:0] en_n = 4'hF; // one first, one second, two first, two second
  logic [8:0] one_in = 9'h000;
  logic [8:0] two_in = 9'h000;
  logic [8:0] one_out, two_out, one_oe_n, two_oe_n;
  logic [41:0] got; // shifted out, first bit at bit 0
  logic bad; // test data out enable wrong around a shift
  int errors = 0;
  int check_count = 0;
  always #10 ref_clk = ~ref_clk;
  // clock enable tied high: freezing is not exercised here
  dbd_top #(.IR_CAPTURE(CAP)) dut_u (
    .REF_CLK(ref_clk), .RESET(reset), .CE(1'b1),
    .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE_N(tdo_oe_n),
    .SIDE_ONE_DATA_IN(one_in), .SIDE_ONE_ENABLE_FIRST_N(en_n[3]), .SIDE_ONE_ENABLE_SECOND_N(en_n[2]),
    .SIDE_ONE_DATA_OUT(one_out), .SIDE_ONE_DATA_OE_N(one_oe_n),
    .SIDE_TWO_DATA_IN(two_in), .SIDE_TWO_ENABLE_FIRST_N(en_n[1]), .SIDE_TWO_ENABLE_SECOND_N(en_n[0]),
    .SIDE_TWO_DATA_OUT(two_out), .SIDE_TWO_DATA_OE_N(two_oe_n)
  );
  dbd_ctl_model ctl_u (.clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [41:0] seen, input logic [41:0] want);
    check_count++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // boundary cells run from pin 0 downward, so lanes appear reversed
  function automatic logic [8:0] rev(input logic [8:0] v);
    for (int i = 0; i < 9; i++) rev[i] = v[8 - i];
  endfunction
  // change pins off the edge, then let the three-flop path settle
  task automatic pins(input logic [3:0] e, input logic [8:0] a, input logic [8:0] b);
    @(negedge ref_clk);
    en_n = e;
    one_in = a;
    two_in = b;
    repeat (4) @(negedge ref_clk);
  endtask
  // data is compared only where its byte is driven
  task automatic outs(input logic [8:0] a, input logic za, input logic [8:0] b, input logic zb);
    check({one_oe_n, two_oe_n}, {{9{za}}, {9{zb}}});
    if (!za) check(one_out, a);
    if (!zb) check(two_out, b);
  endtask
  task automatic ir(input logic [7:0] code);
    ctl_u.scan(1'b1, 8, {34'h0, code}, got, bad);
    check(bad, 1'b0);
  endtask
  task automatic dr(input int n, input logic [41:0] d);
    ctl_u.scan(1'b0, n, d, got, bad);
    check(bad, 1'b0);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // all enables low first, then each single enable high in turn; mode select stays high
  task automatic t_func;
    logic [3:0] e;
    logic [8:0] a;
    for (int k = 0; k < 5; k++) begin
      e = (k == 0) ? 4'h0 : 4'h1 << (k - 1);
      a = 9'h155 ^ 9'(k * 73);
      pins(e, a, ~a);
      outs(a, e[3] | e[2], ~a, e[1] | e[0]);
    end
  endtask
  // slow test clock; the instruction capture reads back the fixed code
  task automatic t_capture;
    ctl_u.half = 7;
    ir(8'hFF);
    check(got[7:0], CAP);
    check(got[1:0], 2'b01);
    ctl_u.half = 4;
  endtask
  // unlisted codes give the one-stage path, which captures zero first
  task automatic t_bypass;
    logic [7:0] codes [4] = '{8'hFF, 8'h80, 8'h01, 8'h7E};
    foreach (codes[i]) begin
      ir(codes[i]);
      dr(8, 42'hB5);
      check(got[7:0], 8'h6A);
    end
  endtask
  // sample watches pins without disturbing them, and preloads the update stage
  task automatic t_sample;
    pins(4'b0100, 9'h123, 9'h0D8);
    ir(CAP);
    outs(9'h123, 1'b1, 9'h0D8, 1'b0);
    dr(42, {6'b001000, 18'h0, rev(9'h1A5), rev(9'h0F3)});
    check(got, {6'b010001, rev(9'h123), rev(9'h0D8), rev(9'h123), rev(9'h0D8)});
    check(got[0], two_in[8]);
    outs(9'h123, 1'b1, 9'h0D8, 1'b0);
  endtask
  // external test: outputs from update cells, each enable cell owns one byte
  task automatic t_extest;
    ir(8'h00);
    outs(9'h1A5, 1'b0, 9'h0F3, 1'b1);
    pins(4'h0, 9'h1FF, 9'h1FF);
    outs(9'h1A5, 1'b0, 9'h0F3, 1'b1);
    dr(42, {6'b000001, 18'h0, rev(9'h00F), rev(9'h16C)});
    outs(9'h00F, 1'b1, 9'h16C, 1'b0);
  endtask
  // clamp holds the update stage, high-z floats all, park restores the path
  task automatic t_hold;
    ir(8'h82);
    dr(2, 42'h3);
    check(got[1:0], 2'b10);
    outs(9'h00F, 1'b1, 9'h16C, 1'b0);
    ir(8'h03);
    dr(2, 42'h3);
    check(got[1:0], 2'b10);
    outs(9'h00F, 1'b1, 9'h16C, 1'b1);
    ctl_u.park();
    outs(9'h1FF, 1'b0, 9'h1FF, 1'b0);
  endtask
  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    ctl_u.park();
    t_func();
    t_capture();
    t_bypass();
    t_sample();
    t_extest();
    t_hold();
    t_func();
    complete_run();
  end
  // a hung run counts as a mismatch
  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
